// ===== logic/ddr_cmd_host.sv
// Purpose: Host side command sequencer that keeps DDR command spacing
// Assumes: ref_clk 25 MHz, memory clock made here at half that rate
// Notes:   Command, cke, bank and address pins change on the falling memory clock edge; read capture is not handled
`timescale 1ns/1ps
`default_nettype none
module ddr_cmd_host
   import ddr_timing_pkg::*;
#(
   parameter int DQ_W = 8
) (
   input  wire logic                ref_clk,
   input  wire logic                rst,
   input  wire logic                reqValid,
   input  wire logic [3:0]          reqCmd,
   input  wire logic [1:0]          reqBank,
   input  wire logic [ROW_W-1:0]    reqAddr,
   input  wire logic [2*DQ_W-1:0]   reqWdata,
   output var  logic                reqAck,
   output var  logic                reqErr,
   output var  logic                refBusy,
   output var  logic                ddrClk,
   output var  logic                ddrClkN,
   output var  logic                cke,
   output var  logic                csN,
   output var  logic                rasN,
   output var  logic                casN,
   output var  logic                weN,
   output var  logic [1:0]          ba,
   output var  logic [ROW_W-1:0]    addr,
   output var  logic [DQ_W-1:0]     dqOut,
   output var  logic                dqOe,
   output var  logic                dqsOut,
   output var  logic                dqsOe
);
   typedef struct packed {
      logic                          clk;
      logic                          clkN;
      logic                          refBusy;
      mode_e                         mode;
      logic                          cke;
      logic [3:0]                    cmd;
      logic [1:0]                    ba;
      logic [ROW_W-1:0]              addr;
      logic [DQ_W-1:0]               dq;
      logic                          dqOe;
      logic                          dqs;
      logic                          dqsOe;
      logic [2*DQ_W-1:0]             wdata;
      logic [2:0]                    wrPh;
      logic                          ack;
      logic                          err;
      logic [CNT_W-1:0]              gap;
      logic [CNT_W-1:0]              xsrd;
      logic [CNT_W-1:0]              wrRec;
      logic [BANKS-1:0][CNT_W-1:0]   rowCnt;
      logic [BANKS-1:0][CNT_W-1:0]   colCnt;
      logic [BANKS-1:0][CNT_W-1:0]   apCnt;
      logic [BANKS-1:0]              open;
      logic [CNT_W-1:0]              refT;
      logic [3:0]                    owed;
   } state_s;

   localparam logic [CNT_W-1:0] LD_MRD  = CNT_W'(MRD_CK - 1);
   localparam logic [CNT_W-1:0] LD_PDEX = CNT_W'(PDEX_CK - 1);
   localparam logic [CNT_W-1:0] LD_XSNR = CNT_W'(XSNR_CK - 1);
   localparam logic [CNT_W-1:0] LD_XSRD = CNT_W'(XSRD_CK - 1);
   localparam logic [CNT_W-1:0] LD_RCD  = CNT_W'(RCD_CK - 1);
   localparam logic [CNT_W-1:0] LD_RAP  = CNT_W'(RAP_CK - 1);
   localparam logic [CNT_W-1:0] LD_RP   = CNT_W'(RP_CK - 1);
   localparam logic [CNT_W-1:0] LD_RFC  = CNT_W'(RFC_CK - 1);
   localparam logic [CNT_W-1:0] LD_REFI = CNT_W'(REFI_CK - 1);
   // Write data ends two memory clocks after the command, so recovery starts two later
   localparam logic [CNT_W-1:0] LD_DAL  = CNT_W'(DAL_CK + 1);
   localparam logic [CNT_W-1:0] LD_WR   = CNT_W'(WR_CK + 1);
   // Read burst of two occupies one clock before precharge may begin
   localparam logic [CNT_W-1:0] LD_RDAP = CNT_W'(RP_CK);
   localparam logic [3:0]       OWE_MAX = 4'(REF_BURST_MAX);

   state_s s_r;
   state_s s_nxt;

   // Next-state: strobe sequencing every cycle, commands on memory clock ticks
   always_comb begin
      logic       tick;
      logic       mustRef;
      logic       legal;
      logic       ready;
      logic       owInc;
      logic       owDec;
      logic [1:0] b;
      tick  = s_r.clk;            // Memory clock falls at this edge
      mustRef = (s_r.owed == OWE_MAX);
      legal = 1'b0;
      ready = 1'b0;
      owInc = 1'b0;
      owDec = 1'b0;
      b     = reqBank;
      s_nxt = s_r;
      s_nxt.clk = ~s_r.clk;
      s_nxt.clkN = s_r.clk;       // Complement kept in its own flop
      s_nxt.ack = 1'b0;
      s_nxt.err = 1'b0;
      // Write strobe and data pins follow the phase count
      if (s_r.wrPh != 3'h0) begin
         s_nxt.wrPh = (s_r.wrPh == WPH_LAST) ? 3'h0 : s_r.wrPh + 3'h1;
      end
      unique case (s_nxt.wrPh)
         WPH_PRE: begin
            s_nxt.dqsOe = 1'b1;
            s_nxt.dqs   = 1'b0;
            s_nxt.dqOe  = 1'b1;
            s_nxt.dq    = s_r.wdata[DQ_W-1:0];
         end
         WPH_B0: begin
            s_nxt.dqs = 1'b1;
         end
         WPH_B1: begin
            s_nxt.dqs = 1'b0;
            s_nxt.dq  = s_r.wdata[2*DQ_W-1:DQ_W];
         end
         WPH_POST: begin
            s_nxt.dqs = 1'b0;
         end
         default: begin
            s_nxt.dqsOe = 1'b0;
            s_nxt.dqOe  = 1'b0;
            s_nxt.dqs   = 1'b0;
         end
      endcase
      if (tick) begin
         s_nxt.cmd = CMD_NOP;
         // Down-counters, one step per memory clock
         if (s_r.gap != '0) s_nxt.gap = s_r.gap - 1'b1;
         if (s_r.xsrd != '0) s_nxt.xsrd = s_r.xsrd - 1'b1;
         if (s_r.wrRec != '0) s_nxt.wrRec = s_r.wrRec - 1'b1;
         for (int i = 0; i < BANKS; i++) begin
            if (s_r.rowCnt[i] != '0) s_nxt.rowCnt[i] = s_r.rowCnt[i] - 1'b1;
            if (s_r.colCnt[i] != '0) s_nxt.colCnt[i] = s_r.colCnt[i] - 1'b1;
            if (s_r.apCnt[i] != '0) s_nxt.apCnt[i] = s_r.apCnt[i] - 1'b1;
         end
         // Interval timer; self refresh keeps the array alive by itself
         if (s_r.mode != MODE_SREF) begin
            if (s_r.refT == LD_REFI) begin
               s_nxt.refT = '0;
               owInc = 1'b1;
            end else begin
               s_nxt.refT = s_r.refT + 1'b1;
            end
         end
         // Refresh wins when owed eight, otherwise only when the user is idle
         if (s_r.mode == MODE_ACTIVE && s_r.owed != 4'h0 && s_r.open == '0 &&
             s_r.gap == '0 && s_r.wrPh == 3'h0 && (mustRef || !reqValid)) begin
            s_nxt.cmd = CMD_REF;
            s_nxt.gap = LD_RFC;
            owDec = 1'b1;
         end else if (reqValid && s_r.gap == '0) begin
            unique case (reqCmd)
               REQ_MRS: begin
                  legal = (s_r.mode == MODE_ACTIVE);
                  ready = (s_r.open == '0) && !mustRef;
                  if (legal && ready) begin
                     s_nxt.cmd = CMD_MRS;
                     s_nxt.gap = LD_MRD;
                  end
               end
               REQ_ACT: begin
                  legal = (s_r.mode == MODE_ACTIVE);
                  ready = !s_r.open[b] && s_r.rowCnt[b] == '0 && !mustRef;
                  if (legal && ready) begin
                     s_nxt.cmd       = CMD_ACT;
                     s_nxt.open[b]   = 1'b1;
                     s_nxt.colCnt[b] = LD_RCD;
                     s_nxt.apCnt[b]  = LD_RAP;
                  end
               end
               REQ_RD, REQ_RDAP: begin
                  legal = (s_r.mode == MODE_ACTIVE) && s_r.open[b];
                  ready = s_r.colCnt[b] == '0 && s_r.xsrd == '0 &&
                          s_r.wrPh == 3'h0 && !mustRef &&
                          (reqCmd == REQ_RD || s_r.apCnt[b] == '0);
                  if (legal && ready) begin
                     s_nxt.cmd = CMD_RD;
                     if (reqCmd == REQ_RDAP) begin
                        s_nxt.open[b]   = 1'b0;
                        s_nxt.rowCnt[b] = LD_RDAP;
                     end
                  end
               end
               REQ_WR, REQ_WRAP: begin
                  legal = (s_r.mode == MODE_ACTIVE) && s_r.open[b];
                  // Owing eight, a bank held open must be closed before more traffic
                  ready = s_r.colCnt[b] == '0 && s_r.wrPh == 3'h0 && !mustRef;
                  if (legal && ready) begin
                     s_nxt.cmd   = CMD_WR;
                     s_nxt.wrPh  = 3'h1;
                     s_nxt.wdata = reqWdata;
                     s_nxt.wrRec = LD_WR;
                     if (reqCmd == REQ_WRAP) begin
                        s_nxt.open[b]   = 1'b0;
                        s_nxt.rowCnt[b] = LD_DAL;
                     end
                  end
               end
               REQ_PRE: begin
                  legal = (s_r.mode == MODE_ACTIVE) && s_r.open[b];
                  ready = s_r.wrRec == '0 && s_r.wrPh == 3'h0;
                  if (legal && ready) begin
                     s_nxt.cmd       = CMD_PRE;
                     s_nxt.open[b]   = 1'b0;
                     s_nxt.rowCnt[b] = LD_RP;
                  end
               end
               REQ_PDEN: begin
                  legal = (s_r.mode == MODE_ACTIVE);
                  ready = s_r.wrPh == 3'h0 && !mustRef;
                  if (legal && ready) begin
                     s_nxt.cke  = 1'b0;
                     s_nxt.mode = MODE_PDOWN;
                  end
               end
               REQ_PDEX: begin
                  legal = (s_r.mode == MODE_PDOWN);
                  ready = 1'b1;
                  if (legal) begin
                     s_nxt.cke  = 1'b1;
                     s_nxt.mode = MODE_ACTIVE;
                     s_nxt.gap  = LD_PDEX;
                  end
               end
               REQ_SREN: begin
                  legal = (s_r.mode == MODE_ACTIVE);
                  ready = s_r.open == '0 && s_r.wrPh == 3'h0;
                  if (legal && ready) begin
                     s_nxt.cmd  = CMD_REF;
                     s_nxt.cke  = 1'b0;
                     s_nxt.mode = MODE_SREF;
                  end
               end
               REQ_SREX: begin
                  legal = (s_r.mode == MODE_SREF);
                  ready = 1'b1;
                  if (legal) begin
                     s_nxt.cke  = 1'b1;
                     s_nxt.mode = MODE_ACTIVE;
                     s_nxt.gap  = LD_XSNR;
                     s_nxt.xsrd = LD_XSRD;
                     s_nxt.refT = '0;
                  end
               end
               default: begin
                  legal = 1'b0;
                  ready = 1'b1;
               end
            endcase
            // Illegal requests answer at once so the user never hangs
            s_nxt.ack = ready || !legal;
            s_nxt.err = !legal;
            if (legal && ready) begin
               s_nxt.ba   = reqBank;
               s_nxt.addr = reqAddr;
               if (reqCmd == REQ_RD || reqCmd == REQ_WR) s_nxt.addr[AP_BIT] = 1'b0;
               if (reqCmd == REQ_RDAP || reqCmd == REQ_WRAP) s_nxt.addr[AP_BIT] = 1'b1;
               if (reqCmd == REQ_PRE) s_nxt.addr[AP_BIT] = 1'b0;
            end
         end
         // Owed count; the cap is never passed because an increment at the cap is dropped
         if (owInc && !owDec && s_r.owed != OWE_MAX) s_nxt.owed = s_r.owed + 4'h1;
         if (owDec && !owInc) s_nxt.owed = s_r.owed - 4'h1;
         if (s_nxt.mode == MODE_SREF) s_nxt.owed = 4'h0;
         s_nxt.refBusy = (s_nxt.owed == OWE_MAX);
      end
   end

   // State register
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         s_r      <= '0;
         s_r.mode <= MODE_ACTIVE;
         s_r.cke  <= 1'b1;
         s_r.clkN <= 1'b1;
         s_r.cmd  <= CMD_NOP;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Pins straight from the state register
   assign ddrClk  = s_r.clk;
   assign ddrClkN = s_r.clkN;
   assign cke     = s_r.cke;
   assign csN     = s_r.cmd[3];
   assign rasN    = s_r.cmd[2];
   assign casN    = s_r.cmd[1];
   assign weN     = s_r.cmd[0];
   assign ba      = s_r.ba;
   assign addr    = s_r.addr;
   assign dqOut   = s_r.dq;
   assign dqOe    = s_r.dqOe;
   assign dqsOut  = s_r.dqs;
   assign dqsOe   = s_r.dqsOe;
   assign reqAck  = s_r.ack;
   assign reqErr  = s_r.err;
   assign refBusy = s_r.refBusy;
endmodule
`default_nettype wire

// ===== logic/ddr_timing_pkg.sv
// Purpose: Constants for the DDR command-spacing host controller
// Assumes: 25 MHz reference clock, memory clock = reference / 2
// Notes:   Figures are the slowest speed grade; cycles round up, interval rounds down
`default_nettype none
package ddr_timing_pkg;
   // Clocking
   localparam int CLK_PS   = 40000;              // Reference clock period
   localparam int TCK_DIV  = 2;                  // Reference cycles per memory clock
   localparam int TCK_PS   = CLK_PS * TCK_DIV;   // Memory clock period
   // Minimum times, picoseconds
   localparam int MRD_PS   = 16000;              // mode_set_to_command_gap
   localparam int PDEX_PS  = 10000;              // powerdown_exit_gap
   localparam int XSNR_PS  = 80000;              // selfrefresh_exit_to_nonread_gap
   localparam int RAP_PS   = 20000;              // Activate to read with auto precharge
   localparam int RCD_PS   = 20000;              // activate_to_column_gap
   localparam int WR_PS    = 15000;              // write_recovery_time
   localparam int RP_PS    = 20000;              // precharge_period
   localparam int RFC_PS   = 80000;              // Refresh to next command
   localparam int REFI_PS  = 7800000;            // average_refresh_interval (maximum)
   localparam int XSRD_CK  = 200;                // selfrefresh_exit_to_read_gap, clocks
   localparam int REF_BURST_MAX = 8;             // Most refreshes owed at once
   // Cycle counts: minimums round up, the interval rounds down
   localparam int MRD_CK   = (MRD_PS  + TCK_PS - 1) / TCK_PS;
   localparam int PDEX_CK  = (PDEX_PS + TCK_PS - 1) / TCK_PS;
   localparam int XSNR_CK  = (XSNR_PS + TCK_PS - 1) / TCK_PS;
   localparam int RAP_CK   = (RAP_PS  + TCK_PS - 1) / TCK_PS;
   localparam int RCD_CK   = (RCD_PS  + TCK_PS - 1) / TCK_PS;
   localparam int WR_CK    = (WR_PS   + TCK_PS - 1) / TCK_PS;
   localparam int RP_CK    = (RP_PS   + TCK_PS - 1) / TCK_PS;
   localparam int RFC_CK   = (RFC_PS  + TCK_PS - 1) / TCK_PS;
   localparam int DAL_CK   = WR_CK + RP_CK;      // autoprecharge_write_recovery_cycles
   localparam int REFI_CK  = REFI_PS / TCK_PS;
   // Widths
   localparam int CNT_W    = 8;
   localparam int ROW_W    = 13;
   localparam int BANKS    = 4;
   localparam int AP_BIT   = 10;                 // Address bit that asks for auto precharge
   // Write strobe phases, reference cycles counted from 1 at the write command
   localparam logic [2:0] WPH_PRE  = 3'h3;       // Preamble, strobe driven low
   localparam logic [2:0] WPH_B0   = 3'h4;       // Strobe high, about a clock after sampling
   localparam logic [2:0] WPH_B1   = 3'h5;       // Strobe low, second beat
   localparam logic [2:0] WPH_POST = 3'h6;       // Postamble, half a memory clock
   localparam logic [2:0] WPH_LAST = 3'h7;       // Released
   // Pin command codes {csN, rasN, casN, weN}
   localparam logic [3:0] CMD_NOP  = 4'h7;
   localparam logic [3:0] CMD_ACT  = 4'h3;
   localparam logic [3:0] CMD_RD   = 4'h5;
   localparam logic [3:0] CMD_WR   = 4'h4;
   localparam logic [3:0] CMD_PRE  = 4'h2;
   localparam logic [3:0] CMD_REF  = 4'h1;
   localparam logic [3:0] CMD_MRS  = 4'h0;
   // User requests
   typedef enum logic [3:0] {
      REQ_MRS = 4'h0, REQ_ACT = 4'h1, REQ_RD = 4'h2, REQ_RDAP = 4'h3,
      REQ_WR = 4'h4, REQ_WRAP = 4'h5, REQ_PRE = 4'h6, REQ_PDEN = 4'h7,
      REQ_PDEX = 4'h8, REQ_SREN = 4'h9, REQ_SREX = 4'ha
   } req_e;
   // Power modes, each one step from active
   typedef enum logic [1:0] {
      MODE_ACTIVE = 2'b00, MODE_PDOWN = 2'b01, MODE_SREF = 2'b10
   } mode_e;
endpackage
`default_nettype wire

// ===== sim/ddr_cmd_host_checker.sv
// Purpose: Port checks on the DDR command host
// Assumes: One ref_clk domain, synchronous reset
// Notes:   Counts in ref cycles, two to a memory clock
`timescale 1ns/1ps
`default_nettype none
module ddr_cmd_host_checker
   import ddr_timing_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic reqAck,
   input wire logic reqErr,
   input wire logic refBusy,
   input wire logic ddrClk,
   input wire logic ddrClkN,
   input wire logic cke,
   input wire logic csN,
   input wire logic rasN,
   input wire logic casN,
   input wire logic weN,
   input wire logic dqOe,
   input wire logic dqsOut,
   input wire logic dqsOe
);
   localparam int SR_MIN = 2 * XSRD_CK - 2;
   logic [3:0] pins;
   logic [9:0] srCnt_r;
   logic       srMode_r;
   logic       ckeSeen_r;
   assign pins = {csN, rasN, casN, weN};
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   // Cycles since self-refresh exit; saturates, and power-down exits do not count as srMode_r is clear
   always_ff @(posedge ref_clk) begin
      ckeSeen_r <= cke;
      if (rst) begin
         srCnt_r  <= 10'h3ff;
         srMode_r <= 1'b0;
      end else if (!cke && pins == CMD_REF) begin
         srMode_r <= 1'b1;
      end else if (cke && !ckeSeen_r && srMode_r) begin
         srMode_r <= 1'b0;
         srCnt_r  <= 10'h000;
      end else if (srCnt_r != 10'h3ff) begin
         srCnt_r <= srCnt_r + 10'h001;
      end
   end
   a_clk_pair_rate: assert property ($rose(ddrClk) |-> !ddrClkN ##1
      ($fell(ddrClk) && ddrClkN) ##1 $rose(ddrClk)) else $error("memory clock pair wrong");
   a_cmd_on_fall: assert property ($changed(pins) |-> $fell(ddrClk))
      else $error("command changed off the falling memory clock");
   a_err_no_cmd: assert property (reqErr |-> reqAck && pins == CMD_NOP)
      else $error("refused request reached the pins");
   a_ack_issues_cmd: assert property (reqAck && !reqErr |-> $fell(ddrClk)
      && (!csN || $changed(cke))) else $error("taken request issued nothing");
   a_busy_only_pre: assert property (reqAck && !reqErr && $past(refBusy)
      |-> pins == CMD_PRE) else $error("non-precharge taken while refresh owed");
   a_busy_drop_ref: assert property ($fell(refBusy) |-> pins == CMD_REF
      || $past(pins) == CMD_REF || $past(pins, 2) == CMD_REF)
      else $error("refresh debt cleared without refresh");
   a_strobe_shape: assert property ($fell(ddrClk) && pins == CMD_WR
      |-> ##2 (dqsOe && !dqsOut && dqOe) ##1 (dqsOe && dqsOut) ##1 (dqsOe && !dqsOut)
      ##1 (dqsOe && !dqsOut) ##1 (!dqsOe || !dqsOut)) else $error("write strobe shape wrong");
   a_read_after_sr: assert property ($fell(ddrClk) && pins == CMD_RD
      |-> srCnt_r >= SR_MIN) else $error("read too soon after self refresh");
endmodule
bind ddr_cmd_host ddr_cmd_host_checker u_ddr_cmd_host_checker (.ref_clk(ref_clk), .rst(rst),
   .reqAck(reqAck), .reqErr(reqErr), .refBusy(refBusy), .ddrClk(ddrClk), .ddrClkN(ddrClkN),
   .cke(cke), .csN(csN), .rasN(rasN), .casN(casN), .weN(weN), .dqOe(dqOe),
   .dqsOut(dqsOut), .dqsOe(dqsOe));
`default_nettype wire

// ===== sim/ddr_mem_model.sv
// Purpose: Behavioural DDR device that counts spacing faults on its pins
// Assumes: Commands sampled at ddrClk rise, strobe sampled on ref_clk
// Notes:   Refresh debt gets one refresh of slack against the host's cap
`timescale 1ns/1ps
`default_nettype none
module ddr_mem_model
   import ddr_timing_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        rst,
   input  wire logic        ddrClk,
   input  wire logic        cke,
   input  wire logic [3:0]  pins,
   input  wire logic [1:0]  ba,
   input  wire logic [12:0] addr,
   input  wire logic [7:0]  dq,
   input  wire logic        dqsOe,
   input  wire logic        dqs,
   output var  int          violCnt,
   output var  logic        wrValid,
   output var  logic [15:0] wrData
);
   // Last times: 0-3 activate, 4-7 write with precharge, 8 mode, 9 pd exit, 10 sr exit, 11 ref
   int         at [12];
   int         tck, tmr, debt, burst, post, ph;
   logic       clkP, ckeP, sr, preOk, dqsP;
   logic [7:0] b0;
   // Everything judged here; behavioural, so blocking updates are intended
   always @(posedge ref_clk) begin
      wrValid <= 1'b0;
      if (rst) begin
         foreach (at[i]) at[i] = -999;
         {tck, tmr, debt, burst, ph, violCnt} = '0;
         {sr, preOk, dqsP, ckeP} = 4'b0001;
      end else begin
         if (ddrClk && !clkP) begin
            tck++;
            tmr = sr ? 0 : tmr + 1;
            if (tmr == REFI_CK) begin
               tmr = 0;
               debt++;
            end
            if (debt > REF_BURST_MAX + 1) violCnt++;
            if (cke && !ckeP) begin
               at[sr ? 10 : 9] = tck;
               debt = sr ? 0 : debt;
               sr = 1'b0;
            end
            if (pins != CMD_NOP) begin
               if (tck - at[8] < MRD_CK || tck - at[9] < PDEX_CK) violCnt++;
               if (pins == CMD_RD && tck - at[10] < XSRD_CK) violCnt++;
               if (pins != CMD_RD && tck - at[10] < XSNR_CK) violCnt++;
               if ((pins == CMD_RD || pins == CMD_WR) && tck - at[ba] < RCD_CK) violCnt++;
               if (pins == CMD_RD && addr[AP_BIT] && tck - at[ba] < RAP_CK) violCnt++;
               if (pins == CMD_ACT && tck - at[4 + ba] < DAL_CK + 1) violCnt++;
               burst = (pins != CMD_REF) ? 0 : (tck - at[11] <= RFC_CK + 1) ? burst + 1 : 1;
               if (burst > REF_BURST_MAX) violCnt++;
               if (pins == CMD_REF && cke) debt--;
               if (pins == CMD_ACT) at[ba] = tck;
               if (pins == CMD_WR && addr[AP_BIT]) at[4 + ba] = tck;
               if (pins == CMD_MRS) at[8] = tck;
               if (pins == CMD_REF) at[11] = tck;
            end
            // Self refresh is a refresh with cke low; power-down drops cke on a no-op
            if (!cke && ckeP && pins == CMD_REF) sr = 1'b1;
            // Kept per memory clock, since cke moves between rises
            ckeP = cke;
         end
         // Beats taken on strobe edges; a short postamble is a fault, a long one is not
         if (dqsOe && dqs && !dqsP) begin
            b0 = dq;
            if (!preOk) violCnt++;
            ph = 1;
         end else if (dqsOe && !dqs && dqsP && ph == 1) begin
            wrData  <= {dq, b0};
            wrValid <= 1'b1;
            ph = 2;
            post = 0;
         end else if (ph == 2 && dqsOe) begin
            post++;
         end else if (ph == 2) begin
            if (post < 1) violCnt++;
            ph = 0;
         end
         preOk = dqsOe && !dqs;
         dqsP  = dqsOe && dqs;
      end
      clkP = ddrClk;
   end
endmodule
`default_nettype wire

// ===== sim/test_ddr_cmd_host.sv
// Purpose: Self-checking bench for the DDR command host
// Assumes: 25 MHz ref_clk, device model on the memory pins
// Notes:   Refresh debt is run up with a bank held open
`timescale 1ns/1ps
`default_nettype none
module test_ddr_cmd_host import ddr_timing_pkg::*; ;
   logic        ref_clk = 1'b0;
   logic        rst = 1'b1;
   logic        reqValid = 1'b0;
   logic [3:0]  reqCmd = 4'h0;
   logic [1:0]  reqBank = 2'h0;
   logic [12:0] reqAddr = 13'h0000;
   logic [15:0] reqWdata = 16'h0000;
   logic        reqAck, reqErr, refBusy, ddrClk, cke, csN, rasN, casN, weN;
   logic        dqOe, dqsOut, dqsOe, wrValid;
   logic [1:0]  ba;
   logic [12:0] addr;
   logic [7:0]  dqOut;
   logic [15:0] wrData;
   logic [31:0] seed = 32'h00002b47;
   int          violCnt, t0;
   int          fails = 0;
   int          compares = 0;
   int          cyc = 0;
   logic        expErrQ [$];
   logic [15:0] expDataQ [$];
   ddr_cmd_host u_ddr_cmd_host (.ref_clk(ref_clk), .rst(rst), .reqValid(reqValid),
      .reqCmd(reqCmd), .reqBank(reqBank), .reqAddr(reqAddr), .reqWdata(reqWdata),
      .reqAck(reqAck), .reqErr(reqErr), .refBusy(refBusy), .ddrClk(ddrClk), .ddrClkN(),
      .cke(cke), .csN(csN), .rasN(rasN), .casN(casN), .weN(weN), .ba(ba), .addr(addr),
      .dqOut(dqOut), .dqOe(dqOe), .dqsOut(dqsOut), .dqsOe(dqsOe));
   ddr_mem_model u_ddr_mem_model (.ref_clk(ref_clk), .rst(rst), .ddrClk(ddrClk), .cke(cke),
      .pins({csN, rasN, casN, weN}), .ba(ba), .addr(addr), .dq(dqOut), .dqsOe(dqsOe),
      .dqs(dqsOut), .violCnt(violCnt), .wrValid(wrValid), .wrData(wrData));
   // Clock and a free cycle count for timed checks
   always #20 ref_clk = ~ref_clk;
   always @(posedge ref_clk) cyc <= cyc + 1;
   function automatic logic [31:0] xorshift();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %0t ns: saw %h, wanted %h", $time, seen, exp);
      end
   endtask
   task automatic tally_and_finish();
      $display("Compares %0d, mismatches %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // One request, held until acknowledged, dropped just after the ack lands
   task automatic req(input req_e c, input logic [1:0] b, input logic expErr);
      logic [15:0] d;
      int          n;
      d = 16'(xorshift());
      @(posedge ref_clk);
      #1;
      reqValid = 1'b1;
      reqCmd   = c;
      reqBank  = b;
      reqAddr  = 13'(xorshift());
      reqWdata = d;
      expErrQ.push_back(expErr);
      if ((c == REQ_WR || c == REQ_WRAP) && !expErr) expDataQ.push_back(d);
      n = 0;
      do begin
         @(posedge ref_clk);
         #1;
         n++;
      end while (reqAck !== 1'b1 && n < 2000);
      if (n >= 2000) fails++;
      reqValid = 1'b0;
   endtask
   // Oldest note matched against each result once outputs settle
   always @(posedge ref_clk) begin
      #2;
      if (reqAck === 1'b1 && expErrQ.size() != 0) check(16'(reqErr), 16'(expErrQ.pop_front()));
      if (wrValid === 1'b1) check(wrData, expDataQ.pop_front());
   end
   // Watchdog well beyond the expected run of a few thousand cycles
   initial begin
      repeat (12000) @(posedge ref_clk);
      fails++;
      tally_and_finish();
   end
   initial begin
      repeat (12) @(posedge ref_clk);
      #1;
      rst = 1'b0;
      req(REQ_PRE, 2'h0, 1'b1); // Bank closed after reset, so refused
      req(REQ_MRS, 2'h0, 1'b0);
      req(REQ_ACT, 2'h2, 1'b0);
      // Open bank blocks refresh, so the debt climbs to its cap
      wait (cyc == 12 + 2 * REFI_CK * REF_BURST_MAX - 40);
      #1 check(16'(refBusy), 16'h0000);
      wait (cyc == 12 + 2 * REFI_CK * REF_BURST_MAX + 40);
      #1 check(16'(refBusy), 16'h0001);
      req(REQ_PRE, 2'h2, 1'b0);
      repeat (100) @(posedge ref_clk);
      #1 check(16'(refBusy), 16'h0000);
      req(REQ_RD, 2'h3, 1'b1);
      req(REQ_PDEX, 2'h0, 1'b1);
      req(REQ_SREX, 2'h0, 1'b1);
      req(REQ_ACT, 2'h0, 1'b0);
      req(REQ_WR, 2'h0, 1'b0);
      repeat (8) @(posedge ref_clk);
      req(REQ_ACT, 2'h1, 1'b0);
      req(REQ_WRAP, 2'h1, 1'b0);
      t0 = cyc;
      req(REQ_ACT, 2'h1, 1'b0);
      check(16'(cyc - t0 >= 2 * (DAL_CK + 1)), 16'h0001);
      req(REQ_PRE, 2'h0, 1'b0);
      req(REQ_ACT, 2'h0, 1'b0);
      req(REQ_RDAP, 2'h0, 1'b0);
      req(REQ_PRE, 2'h1, 1'b0);
      req(REQ_PDEN, 2'h0, 1'b0);
      repeat (10) @(posedge ref_clk);
      req(REQ_PDEX, 2'h0, 1'b0);
      req(REQ_ACT, 2'h2, 1'b0);
      req(REQ_PRE, 2'h2, 1'b0);
      req(REQ_SREN, 2'h0, 1'b0);
      repeat (40) @(posedge ref_clk);
      req(REQ_SREX, 2'h0, 1'b0);
      t0 = cyc;
      req(REQ_ACT, 2'h0, 1'b0);
      req(REQ_RD, 2'h0, 1'b0);
      check(16'(cyc - t0 >= 2 * XSRD_CK - 2), 16'h0001);
      req(REQ_WR, 2'h0, 1'b0);
      repeat (10) @(posedge ref_clk);
      req(REQ_PRE, 2'h0, 1'b0);
      repeat (20) @(posedge ref_clk);
      check(16'(violCnt), 16'h0000);
      tally_and_finish();
   end
endmodule
`default_nettype wire
